// *** hw/dpsf_defs.svh ***
// constants for the host-side flag controller
// assumes a 20 MHz clk_i; device pins are asynchronous to it
// Behaviour
// R01: eight flags in separate space
// R02: flag select low, sram-like access
// R03: low three address lines pick flag
// R04: only data bit zero written
// R05: write zero requests, one releases
// R06: granted flag reads zero here only
// R07: owned flag changed only by owner
// R08: owner writing one frees flag
// R09: losing zero held in request latch
// R10: release passes token to pending side
// R11: read value replicated on all bits
// R12: read value latched while selected
// R13: host deasserts select between polls
// R14: acquire by write then read back
// R15: after failure retry or withdraw
// R16: earlier requester wins simultaneous requests
// R17: contention window settles to one side
// R18: host writes one to all flags at init
// R19: both selects high means standby
// R20: ports independent of each other
// R21: flag accesses free of collisions
// R22: flags gate no hardware resource
// R23: flags power up undefined
`ifndef DPSF_DEFS_SVH
`define DPSF_DEFS_SVH
`define DPSF_CLK_MHZ      20
`define DPSF_NUM_FLAGS    8
`define DPSF_WR_PULSE_NS  60
`define DPSF_WR_TO_RD_NS  10
`define DPSF_RD_ACC_NS    70
`define DPSF_GAP_NS       20
`define DPSF_CYC(ns)      ((((ns) * `DPSF_CLK_MHZ) + 999) / 1000 + 1)
`endif

// *** hw/dpsf_pkg.sv ***
// types for the host-side flag controller
// assumes dpsf_defs.svh for numeric constants
package dpsf_pkg;
    typedef enum logic [1:0] {
        DPSF_OP_INIT,
        DPSF_OP_ACQUIRE,
        DPSF_OP_RELEASE,
        DPSF_OP_READ
    } dpsf_op_t;

    typedef struct packed {
        logic       flag_space_select_n;
        logic       oe_n;
        logic       rw_n;
        logic [2:0] flag_index;
        logic       d_out;
        logic       d_oe_n;
    } dpsf_pins_t;

    typedef struct packed {
        dpsf_op_t   op;
        logic [2:0] flag_index;
    } dpsf_req_t;
endpackage : dpsf_pkg

// *** hw/dpsf_sync.sv ***
// three-stage synchroniser for the device read data
// assumes asynchronous input; change counts when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dpsf_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dpsf_sync_st_t;
    dpsf_sync_st_t st;
    dpsf_sync_st_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q_o = st.q;
endmodule : dpsf_sync
`default_nettype wire

// *** hw/dpsf_host.sv ***
// host controller driving one port of the dual-port flag device
// assumes device pins are asynchronous; write then read-back protocol
`timescale 1ns/1ps
`default_nettype none
`include "dpsf_defs.svh"
module dpsf_host
    import dpsf_pkg::*;
#(
    parameter int NUM_FLAGS = `DPSF_NUM_FLAGS
) (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       req_valid_i,
    input  wire dpsf_req_t  req_i,
    output logic            req_ready_o,
    output logic            done_o,
    output logic            granted_o,
    output logic [7:0]      rd_data_o,
    input  wire logic [7:0] dev_d_i,
    output dpsf_pins_t      pins_o,
    output logic            ce_n_o
);
    localparam int WR_CYC  = `DPSF_CYC(`DPSF_WR_PULSE_NS);
    localparam int W2R_CYC = `DPSF_CYC(`DPSF_WR_TO_RD_NS);
    localparam int RD_CYC  = `DPSF_CYC(`DPSF_RD_ACC_NS) + 4;
    localparam int GAP_CYC = `DPSF_CYC(`DPSF_GAP_NS);

    typedef enum logic [2:0] {
        S_IDLE, S_WRITE, S_W2R, S_READ, S_GAP
    } dpsf_state_t;

    typedef struct packed {
        dpsf_state_t state;
        logic [3:0]  cnt;
        dpsf_op_t    op;
        logic [2:0]  idx;
        logic [3:0]  init_idx;
        logic        ready;
        logic        done;
        logic        granted;
        logic [7:0]  rd;
        dpsf_pins_t  pins;
        logic        ce_n;
    } dpsf_st_t;

    dpsf_st_t   st;
    dpsf_st_t   next_st;
    logic [7:0] d_sync;

    dpsf_sync #(.W(8)) dpsf_sync_i (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .d_i       (dev_d_i),
        .q_o       (d_sync)
    );

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        next_st.cnt  = (st.cnt == 4'h0) ? 4'h0 : st.cnt - 4'h1;
        // memory select held high: this controller only touches flag space
        next_st.ce_n = 1'b1; // R01 R22
        case (st.state)
            S_IDLE: begin
                // idle port: both selects high, standby
                next_st.pins.flag_space_select_n = 1'b1; // R19
                next_st.pins.oe_n   = 1'b1;
                next_st.pins.rw_n   = 1'b1;
                next_st.pins.d_oe_n = 1'b1;
                next_st.ready       = 1'b1;
                if (req_valid_i && st.ready) begin
                    next_st.ready = 1'b0;
                    next_st.op    = req_i.op;
                    next_st.idx   = req_i.flag_index; // R03
                    next_st.init_idx = 4'h0;
                    if (req_i.op == DPSF_OP_READ) begin
                        next_st.state     = S_READ;
                        next_st.cnt       = 4'(RD_CYC);
                        next_st.pins.flag_space_select_n = 1'b0; // R02
                        next_st.pins.oe_n  = 1'b0;
                        next_st.pins.flag_index = req_i.flag_index;
                    end else begin
                        next_st.state      = S_WRITE;
                        next_st.cnt        = 4'(WR_CYC);
                        next_st.pins.flag_space_select_n = 1'b0; // R02
                        next_st.pins.rw_n  = 1'b0;
                        next_st.pins.d_oe_n = 1'b0;
                        // zero requests, one releases; init frees flags
                        next_st.pins.d_out = (req_i.op != DPSF_OP_ACQUIRE); // R05 R04 R15
                        next_st.pins.flag_index =
                            (req_i.op == DPSF_OP_INIT) ? 3'h0 : req_i.flag_index;
                    end
                end
            end
            S_WRITE: begin
                if (st.cnt == 4'h0) begin
                    next_st.pins.rw_n   = 1'b1;
                    next_st.pins.flag_space_select_n = 1'b1;
                    next_st.pins.d_oe_n = 1'b1;
                    next_st.state       = S_W2R;
                    next_st.cnt         = 4'(W2R_CYC);
                end
            end
            S_W2R: begin
                if (st.cnt == 4'h0) begin
                    if (st.op == DPSF_OP_INIT) begin
                        // free every flag from this side
                        if (st.init_idx == 4'(NUM_FLAGS - 1)) begin // R18
                            next_st.state = S_GAP;
                            next_st.cnt   = 4'(GAP_CYC);
                            next_st.done  = 1'b1;
                        end else begin
                            next_st.init_idx = st.init_idx + 4'h1;
                            next_st.pins.flag_index = 3'(st.init_idx + 4'h1);
                            next_st.pins.flag_space_select_n = 1'b0;
                            next_st.pins.rw_n   = 1'b0;
                            next_st.pins.d_oe_n = 1'b0;
                            next_st.state = S_WRITE;
                            next_st.cnt   = 4'(WR_CYC);
                        end
                    end else if (st.op == DPSF_OP_ACQUIRE) begin
                        // always write then read back
                        next_st.pins.flag_space_select_n = 1'b0; // R14
                        next_st.pins.oe_n  = 1'b0;
                        next_st.state = S_READ;
                        next_st.cnt   = 4'(RD_CYC);
                    end else begin
                        next_st.state = S_GAP;
                        next_st.cnt   = 4'(GAP_CYC);
                        next_st.done  = 1'b1;
                    end
                end
            end
            S_READ: begin
                if (st.cnt == 4'h0) begin
                    next_st.rd = d_sync; // R11
                    next_st.granted = (st.op == DPSF_OP_ACQUIRE) ? (d_sync[0] == 1'b0) : st.granted; // R14
                    // drop select so the next poll recaptures the flag
                    next_st.pins.flag_space_select_n = 1'b1; // R13
                    next_st.pins.oe_n  = 1'b1;
                    next_st.done  = 1'b1;
                    next_st.state = S_GAP;
                    next_st.cnt   = 4'(GAP_CYC);
                end
            end
            S_GAP: begin
                if (st.cnt == 4'h0) begin
                    next_st.state = S_IDLE;
                    next_st.ready = 1'b1;
                end
            end
            default: begin
                next_st.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st       <= '0;
            st.state <= S_IDLE;
            st.ce_n  <= 1'b1;
            st.pins  <= '{flag_space_select_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1, flag_index: 3'h0,
                          d_out: 1'b1, d_oe_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign req_ready_o = st.ready;
    assign done_o      = st.done;
    assign granted_o   = st.granted;
    assign rd_data_o   = st.rd;
    assign pins_o      = st.pins;
    assign ce_n_o      = st.ce_n;

    // pin protocol: selects, strobes and write data of this port
    AST_SELECT_EXCLUSIVE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R02
        !(st.pins.flag_space_select_n == 1'b0 && ce_n_o == 1'b0)) else $error("memory and flag select both low");
    AST_MEM_SELECT_HIGH: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R22
        ce_n_o == 1'b1) else $error("memory select driven low");
    AST_WRITE_DATA: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R05
        (!st.pins.rw_n && st.op == DPSF_OP_ACQUIRE) |-> st.pins.d_out == 1'b0) else $error("acquire not writing zero");
    AST_RELEASE_ONE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R15
        (!st.pins.rw_n && st.op != DPSF_OP_ACQUIRE) |-> st.pins.d_out == 1'b1) else $error("release not writing one");
    AST_WRITE_DRIVES_DATA: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R05
        !st.pins.rw_n |-> !st.pins.d_oe_n) else $error("write strobe without data driven");
    AST_READ_NO_WRITE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R02
        (!st.pins.flag_space_select_n && !st.pins.oe_n) |-> st.pins.rw_n) else $error("read and write at once");
    // write strobe must outlast the minimum pulse at this clock
    AST_WRITE_PULSE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R02
        $fell(st.pins.rw_n) |-> !st.pins.rw_n [*4]) else $error("write pulse too short");

    // read-back and polling discipline
    AST_READ_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R02
        $fell(st.pins.oe_n) |-> !st.pins.oe_n [*8]) else $error("read strobe too short");
    AST_POLL_GAP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
        $rose(st.pins.oe_n) |-> st.pins.flag_space_select_n [*2]) else $error("select not dropped after read");
    AST_GAP_DESELECT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
        st.state == S_GAP |-> st.pins.flag_space_select_n && st.pins.oe_n) else $error("select held across gap");
    AST_WRITE_BEFORE_READ: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
        (st.state == S_READ && st.op == DPSF_OP_ACQUIRE) |-> st.pins.rw_n) else $error("read overlapped write");
    AST_ACQ_READBACK: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
        (st.state == S_W2R && st.op == DPSF_OP_ACQUIRE && st.cnt == 4'h0)
        |=> (st.state == S_READ && !st.pins.flag_space_select_n && !st.pins.oe_n)) else $error("no read-back after write");

    // sequencing of whole requests
    AST_STANDBY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R19
        st.state == S_IDLE |-> st.pins.flag_space_select_n && st.pins.oe_n && st.pins.rw_n && st.pins.d_oe_n)
        else $error("idle port not in standby");
    AST_INIT_DONE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R18
        (st.op == DPSF_OP_INIT && next_st.done) |-> st.init_idx == 4'(NUM_FLAGS - 1)) else $error("init ended early");
    AST_DONE_PULSE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
        done_o |=> !done_o) else $error("done longer than one cycle");

    // main scenarios
    COV_ACQ: cover property (@(posedge clk_i) done_o && granted_o && st.op == DPSF_OP_ACQUIRE);
    COV_FAIL: cover property (@(posedge clk_i) done_o && !granted_o && st.op == DPSF_OP_ACQUIRE);
    COV_INIT: cover property (@(posedge clk_i) done_o && st.op == DPSF_OP_INIT);
    COV_READ: cover property (@(posedge clk_i) done_o && st.op == DPSF_OP_READ);
    COV_RELEASE: cover property (@(posedge clk_i) done_o && st.op == DPSF_OP_RELEASE);
endmodule : dpsf_host
`default_nettype wire

// *** tb/dpsf_dev_model.sv ***
// device model: eight flags shared by host port a and bench port b
// assumes port a pins come from the host, port b from the bench
`timescale 1ns/1ps
`default_nettype none
module dpsf_dev_model
    import dpsf_pkg::*;
(
    input  wire dpsf_pins_t a_pins_i,
    output logic [7:0]      a_d_o,
    input  wire logic       b_flag_space_select_n_i,
    input  wire logic       b_oe_n_i,
    input  wire logic       b_rw_n_i,
    input  wire logic [2:0] b_idx_i,
    input  wire logic       b_d0_i,
    output logic [7:0]      b_d_o
);
    logic [1:0] own [8]; // 0 free, 1 a, 2 b
    logic       ra [8];
    logic       rb [8];
    logic       aq, bq, ad;
    logic [2:0] ai;
    wire aw = ~a_pins_i.flag_space_select_n & ~a_pins_i.rw_n;
    wire ar = ~a_pins_i.flag_space_select_n & ~a_pins_i.oe_n & a_pins_i.rw_n;
    wire bw = ~b_flag_space_select_n_i & ~b_rw_n_i;
    wire br = ~b_flag_space_select_n_i & ~b_oe_n_i & b_rw_n_i;
    initial for (int i = 0; i < 8; i++) begin
        own[i] = 2'bxx;
        ra[i] = 1'bx;
        rb[i] = 1'bx;
    end
    // owner keeps flag until it writes one, then pending side wins
    function automatic logic [1:0] settle(logic [1:0] o, logic x, logic y);
        if (o === 2'd1 && x !== 1'b1) return o;
        if (o === 2'd2 && y !== 1'b1) return o;
        if (x === 1'b0) return 2'd1;
        if (y === 1'b0) return 2'd2;
        if (x === 1'b1 && y === 1'b1) return 2'd0;
        return 2'bxx;
    endfunction : settle
    // capture while selected; pins drop together at the end of write
    always @* if (aw) begin
        ai = a_pins_i.flag_index;
        ad = a_pins_i.d_oe_n ? 1'bx : a_pins_i.d_out;
    end
    always @(negedge aw) begin
        ra[ai] = ad;
        own[ai] = settle(own[ai], ra[ai], rb[ai]);
    end
    always @(negedge bw) begin
        rb[b_idx_i] = b_d0_i;
        own[b_idx_i] = settle(own[b_idx_i], ra[b_idx_i], rb[b_idx_i]);
    end
    always @(posedge ar) aq = ~(own[a_pins_i.flag_index] == 2'd1);
    always @(posedge br) bq = ~(own[b_idx_i] == 2'd2);
    // released bus shows inverse of last value; no memory array gated
    assign a_d_o = ar ? {8{aq}} : {8{~aq}};
    assign b_d_o = br ? {8{bq}} : {8{~bq}};
endmodule : dpsf_dev_model
`default_nettype wire

// *** tb/tb_dual_port_semaphore_flags.sv ***
// bench for the host flag controller against a two-port device model
// assumes the bench acts as the processor on the far port b
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_semaphore_flags;
    import dpsf_pkg::*;
    logic clk_i = 0, reset_n_i = 0, req_valid_i = 0;
    dpsf_req_t  req_i = '0;
    logic req_ready_o, done_o, granted_o, ce_n_o;
    logic [7:0] rd_data_o, dev_d, b_d;
    dpsf_pins_t pins_o;
    logic b_flag_space_select_n = 1, b_oe_n = 1, b_rw_n = 1, b_d0 = 1;
    logic [2:0] b_idx = '0;
    int fails = 0, n_tests = 0, cyc = 0;
    dpsf_host dpsf_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .granted_o(granted_o),
        .rd_data_o(rd_data_o), .dev_d_i(dev_d), .pins_o(pins_o), .ce_n_o(ce_n_o));
    dpsf_dev_model dpsf_dev_model_i (.a_pins_i(pins_o), .a_d_o(dev_d),
        .b_flag_space_select_n_i(b_flag_space_select_n), .b_oe_n_i(b_oe_n), .b_rw_n_i(b_rw_n),
        .b_idx_i(b_idx), .b_d0_i(b_d0), .b_d_o(b_d));
    initial forever #25 clk_i = ~clk_i;
    task automatic summarize;
        $display("counts: tests=%0d fails=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // hang guard, generous against about 570 cycles of traffic
    always @(posedge clk_i) if (++cyc >= 20000) begin
        fails++;
        summarize();
    end
    task automatic chk8(input logic [7:0] g, e);
        n_tests++;
        if (g !== e) begin fails++; $display("FAIL %0t data %h want %h", $time, g, e); end
    endtask : chk8
    task automatic chk1(input logic g, e);
        n_tests++;
        if (g !== e) begin fails++; $display("FAIL %0t bit %b want %b", $time, g, e); end
    endtask : chk1
    task automatic op(input dpsf_op_t o, input logic [2:0] i);
        int n = 0;
        while (req_ready_o !== 1'b1 && n < 300) begin @(posedge clk_i); #1; n++; end
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{op: o, flag_index: i};
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        do begin @(posedge clk_i); #1; n++; end while (done_o !== 1'b1 && n < 400);
        chk1(done_o, 1'b1);
    endtask : op
    // far-side processor, asynchronous to clk_i
    task automatic bw(input logic [2:0] i, input logic v);
        b_idx = i; b_d0 = v; b_flag_space_select_n = 0; b_rw_n = 0;
        #60 b_rw_n = 1; b_flag_space_select_n = 1;
        #20;
    endtask : bw
    task automatic brd(input logic [2:0] i, input logic [7:0] e);
        b_idx = i; b_flag_space_select_n = 0; b_oe_n = 0;
        #70 chk8(b_d, e);
        b_flag_space_select_n = 1; b_oe_n = 1; // drop select between polls
        #20;
    endtask : brd
    task automatic t_init;
        op(DPSF_OP_INIT, 3'h0);
        for (int i = 0; i < 8; i++) bw(i[2:0], 1'b1);
        for (int i = 0; i < 8; i++) begin
            op(DPSF_OP_READ, i[2:0]);
            chk8(rd_data_o, 8'hff);
            brd(i[2:0], 8'hff);
        end
        $display("init done fails=%0d", fails);
    endtask : t_init
    task automatic t_lock;
        op(DPSF_OP_ACQUIRE, 3'h5);
        chk1(granted_o, 1'b1);
        chk8(rd_data_o, 8'h00);
        brd(3'h5, 8'hff);
        bw(3'h5, 1'b0);
        brd(3'h5, 8'hff);
        op(DPSF_OP_READ, 3'h5);
        chk8(rd_data_o, 8'h00);
        op(DPSF_OP_RELEASE, 3'h5);
        brd(3'h5, 8'h00);
        op(DPSF_OP_ACQUIRE, 3'h5);
        chk1(granted_o, 1'b0);
        chk8(rd_data_o, 8'hff);
        op(DPSF_OP_RELEASE, 3'h5);
        bw(3'h5, 1'b1);
        op(DPSF_OP_READ, 3'h5);
        chk8(rd_data_o, 8'hff);
        $display("lock done fails=%0d", fails);
    endtask : t_lock
    task automatic t_all;
        for (int i = 0; i < 8; i++) begin
            op(DPSF_OP_ACQUIRE, i[2:0]);
            chk1(granted_o, 1'b1);
            brd(i[2:0], 8'hff);
        end
        bw(3'h2, 1'b0);
        for (int i = 0; i < 8; i++) op(DPSF_OP_RELEASE, i[2:0]);
        brd(3'h2, 8'h00);
        op(DPSF_OP_ACQUIRE, 3'h2);
        chk1(granted_o, 1'b0);
        bw(3'h2, 1'b1);
        op(DPSF_OP_READ, 3'h2);
        chk8(rd_data_o, 8'h00);
        op(DPSF_OP_RELEASE, 3'h2);
        brd(3'h0, 8'hff);
        chk1(ce_n_o, 1'b1);
        $display("all done fails=%0d", fails);
    endtask : t_all
    initial begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_init();
        t_lock();
        t_all();
        summarize();
    end
endmodule : tb_dual_port_semaphore_flags
`default_nettype wire
